// >>> dprh_defines.svh
// timing and field constants for the dual-port ram port controller
// assumes a 100 MHz system clock and the fastest speed grade of the ram
`ifndef DPRH_DEFINES_SVH
`define DPRH_DEFINES_SVH

`define DPRH_ADDR_W        14
`define DPRH_DATA_W        9
`define DPRH_SEM_ADDR_W    3
`define DPRH_TMR_W         4
`define DPRH_SEM_BIT       0

`define DPRH_CLK_NS        10
`define DPRH_T_AA_NS       15
`define DPRH_T_PWE_NS      12
`define DPRH_T_BLA_NS      15
`define DPRH_T_SOP_NS      10

// least times round up to whole cycles
`define DPRH_CEIL_CYC(ns)  (((ns) + `DPRH_CLK_NS - 1) / `DPRH_CLK_NS)
`define DPRH_AA_CYC        `DPRH_CEIL_CYC(`DPRH_T_AA_NS)
`define DPRH_PWE_CYC       `DPRH_CEIL_CYC(`DPRH_T_PWE_NS)
`define DPRH_BLA_CYC       `DPRH_CEIL_CYC(`DPRH_T_BLA_NS)
`define DPRH_SOP_CYC       `DPRH_CEIL_CYC(`DPRH_T_SOP_NS)
`define DPRH_MIN_CYC       1

`endif

// >>> dprh_pkg.sv
// types shared by the dual-port ram port controller
// assumes dprh_defines.svh for the widths
`include "dprh_defines.svh"
`default_nettype none

package dprh_pkg;
  typedef logic [`DPRH_ADDR_W-1:0] dprh_addr_t;
  typedef logic [`DPRH_DATA_W-1:0] dprh_data_t;
  typedef logic [`DPRH_TMR_W-1:0]  dprh_cnt_t;

  typedef enum logic [2:0] {
    DPRH_IDLE,
    DPRH_SETUP,
    DPRH_WRPULSE,
    DPRH_WRHOLD,
    DPRH_RDWAIT,
    DPRH_GAP
  } dprh_state_e;

  typedef struct packed {
    dprh_state_e st;
    logic        is_write;
    logic        is_sem;
    logic        ce_n;
    logic        sem_n;
    logic        rw_n;
    logic        oe_n;
    dprh_addr_t  addr;
    dprh_data_t  dout;
    logic        dout_en;
    dprh_data_t  rdata;
    logic        ready;
    logic        done;
    logic        mbox;
  } dprh_host_s;

  typedef struct packed {
    dprh_cnt_t cnt;
  } dprh_tmr_s;
endpackage

`default_nettype wire

// >>> dprh_timer.sv
// down counter that times the phases of one ram access
// assumes load values of at least one cycle
`include "dprh_defines.svh"
`default_nettype none

module dprh_timer (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // control
  input  wire logic             load,
  input  wire dprh_pkg::dprh_cnt_t val,
  // status
  output logic                  expired
);
  import dprh_pkg::*;

  dprh_tmr_s s_q;
  dprh_tmr_s s_d;

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.cnt = val;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - dprh_cnt_t'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expired = (s_q.cnt == '0);
endmodule

`default_nettype wire

// >>> dprh_host.sv
// host controller driving one port of an asynchronous dual-port static ram
// assumes pin inputs synchronous to clk and one request at a time
`include "dprh_defines.svh"
`default_nettype none

module dprh_host (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // user request
  input  wire logic                req,
  input  wire logic                op_write,
  input  wire logic                op_sem,
  input  wire dprh_pkg::dprh_addr_t req_addr,
  input  wire dprh_pkg::dprh_data_t req_wdata,
  // user answer
  output logic                     ready,
  output logic                     done,
  output dprh_pkg::dprh_data_t     rdata,
  output logic                     mbox_flag,
  // ram port pins
  output logic                     ce_n,
  output logic                     sem_n,
  output logic                     rw_n,
  output logic                     oe_n,
  output dprh_pkg::dprh_addr_t     addr,
  output dprh_pkg::dprh_data_t     dq_o,
  output logic                     dq_oe,
  input  wire dprh_pkg::dprh_data_t dq_i,
  input  wire logic                busy_n,
  input  wire logic                int_n
);
  import dprh_pkg::*;

  dprh_host_s s_q;
  dprh_host_s s_d;
  logic       tmr_load;
  dprh_cnt_t  tmr_val;
  logic       tmr_exp;

  dprh_timer u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (tmr_load),
    .val     (tmr_val),
    .expired (tmr_exp)
  );

  // semaphore address keeps only the latch index bits
  function automatic dprh_addr_t sem_addr(input dprh_addr_t a);
    sem_addr = '0;
    sem_addr[`DPRH_SEM_ADDR_W-1:0] = a[`DPRH_SEM_ADDR_W-1:0];
  endfunction

  always_comb begin
    s_d      = s_q;
    tmr_load = 1'b0;
    tmr_val  = dprh_cnt_t'(`DPRH_MIN_CYC);
    s_d.done = 1'b0;
    s_d.mbox = ~int_n;
    case (s_q.st)
      DPRH_IDLE: begin
        if (req) begin
          s_d.is_write = op_write;
          s_d.is_sem   = op_sem;
          s_d.ready    = 1'b0;
          // address moves only here, strobe high
          s_d.addr     = op_sem ? sem_addr(req_addr) : req_addr;
          s_d.dout     = op_sem ? {{(`DPRH_DATA_W-1){1'b0}}, req_wdata[`DPRH_SEM_BIT]}
                                : req_wdata;
          s_d.ce_n     = op_sem;
          s_d.sem_n    = ~op_sem;
          s_d.st       = DPRH_SETUP;
          tmr_load     = 1'b1;
          tmr_val      = dprh_cnt_t'(`DPRH_BLA_CYC);
        end
      end
      DPRH_SETUP: begin
        // let busy settle, then for a memory access hold off while the other port owns it
        if (tmr_exp && (s_q.is_sem || busy_n)) begin
          tmr_load = 1'b1;
          if (s_q.is_write) begin
            s_d.rw_n    = 1'b0;
            s_d.dout_en = 1'b1;
            s_d.st      = DPRH_WRPULSE;
            tmr_val     = dprh_cnt_t'(`DPRH_PWE_CYC);
          end else begin
            s_d.oe_n = 1'b0;
            s_d.st   = DPRH_RDWAIT;
            tmr_val  = dprh_cnt_t'(`DPRH_AA_CYC);
          end
        end
      end
      DPRH_WRPULSE: begin
        if (tmr_exp) begin
          s_d.rw_n = 1'b1;
          s_d.st   = DPRH_WRHOLD;
        end
      end
      DPRH_WRHOLD: begin
        // strobe already high: drop select and data drive
        s_d.ce_n    = 1'b1;
        s_d.sem_n   = 1'b1;
        s_d.dout_en = 1'b0;
        s_d.st      = DPRH_GAP;
        tmr_load    = 1'b1;
        tmr_val     = s_q.is_sem ? dprh_cnt_t'(`DPRH_SOP_CYC)
                                 : dprh_cnt_t'(`DPRH_MIN_CYC);
      end
      DPRH_RDWAIT: begin
        if (tmr_exp) begin
          // capture, then deselect so the next access starts clean
          s_d.rdata = dq_i;
          s_d.oe_n  = 1'b1;
          s_d.ce_n  = 1'b1;
          s_d.sem_n = 1'b1;
          s_d.st    = DPRH_GAP;
          tmr_load  = 1'b1;
          tmr_val   = dprh_cnt_t'(`DPRH_SOP_CYC);
        end
      end
      DPRH_GAP: begin
        // deselected gap also covers the flag update pulse
        if (tmr_exp) begin
          s_d.done  = 1'b1;
          s_d.ready = 1'b1;
          s_d.st    = DPRH_IDLE;
        end
      end
      default: begin
        s_d.st = DPRH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q       <= '0;
      s_q.st    <= DPRH_IDLE;
      s_q.ce_n  <= 1'b1;
      s_q.sem_n <= 1'b1;
      s_q.rw_n  <= 1'b1;
      s_q.oe_n  <= 1'b1;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign ready     = s_q.ready;
  assign done      = s_q.done;
  assign rdata     = s_q.rdata;
  assign mbox_flag = s_q.mbox;
  assign ce_n      = s_q.ce_n;
  assign sem_n     = s_q.sem_n;
  assign rw_n      = s_q.rw_n;
  assign oe_n      = s_q.oe_n;
  assign addr      = s_q.addr;
  assign dq_o      = s_q.dout;
  assign dq_oe     = s_q.dout_en;

  // pin-level checks of the access sequence
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_write_select: assert property (!rw_n |-> (ce_n != sem_n))
    else $error("write strobe low without exactly one select");
  chk_data_hold: assert property ($rose(rw_n) |-> dq_oe && $stable(dq_o))
    else $error("write data not held at strobe rise");
  chk_pulse_width: assert property ($fell(rw_n) |-> (!rw_n && oe_n)[*2])
    else $error("write pulse short or output drive on");
  chk_addr_stable: assert property (!$stable(addr) |-> rw_n && $past(rw_n))
    else $error("address changed with write strobe low");
  chk_ram_select: assert property (!ce_n |-> sem_n)
    else $error("memory select with flag select low");
  chk_sem_select: assert property (!sem_n |-> ce_n)
    else $error("flag select with memory select low");
  chk_sem_gap: assert property ($rose(rw_n) && !sem_n |=> sem_n && oe_n)
    else $error("no deselect gap after semaphore write");
  chk_busy_wait: assert property ($fell(rw_n) && sem_n |-> $past(busy_n))
    else $error("memory write started while busy");
  chk_done_pulse: assert property (done |-> ready ##1 !done)
    else $error("done not a single pulse");
  // own drivers stay off while the ram drives the bus
  chk_read_drive: assert property (!oe_n |-> rw_n && !dq_oe)
    else $error("output drive on with strobe low or data driven");
  chk_strobe_data: assert property (!rw_n |-> dq_oe && oe_n)
    else $error("write strobe low without write data driven");
  chk_sem_index: assert property (!sem_n |-> (addr >> `DPRH_SEM_ADDR_W) == '0)
    else $error("semaphore access with upper address bits set");
  chk_idle_deselect: assert property (ready |-> ce_n && sem_n)
    else $error("port selected while idle");
  chk_read_release: assert property ($rose(oe_n) |-> ce_n && sem_n)
    else $error("read ended without deselect");

  cov_ram_write: cover property ($fell(rw_n) && !ce_n ##[1:20] done);
  cov_ram_read: cover property ($fell(oe_n) && !ce_n ##[1:20] done);
  cov_sem_write: cover property ($fell(rw_n) && !sem_n ##[1:20] done);
  cov_sem_read: cover property ($fell(oe_n) && !sem_n ##[1:20] done);
  cov_busy_stall: cover property (!ce_n && !busy_n ##1 !ce_n && !busy_n);
endmodule

`default_nettype wire

// >>> dprh_ram_model.sv
// behavioural model of one port of the dual-port ram, far port reduced to three controls
// assumes the host controller drives the pins off clk
`default_nettype none
module dprh_ram_model (
  // ram pins
  input  wire logic                 clk,
  input  wire logic                 ce_n,
  input  wire logic                 sem_n,
  input  wire logic                 rw_n,
  input  wire logic                 oe_n,
  input  wire logic                 dq_oe,
  input  wire dprh_pkg::dprh_addr_t addr,
  input  wire dprh_pkg::dprh_data_t dq_o,
  output dprh_pkg::dprh_data_t      dq_i,
  output logic                      busy_n,
  output logic                      int_n,
  // far port
  input  wire logic                 stall,
  input  wire logic                 peer_mbox,
  input  wire logic [7:0]           peer_own
);
  timeunit 1ns;
  timeprecision 1ps;
  import dprh_pkg::*;
  dprh_data_t mem [0:16383];
  logic [7:0] req_q = '0;
  dprh_data_t last_q = '0;
  // a pending claim is granted as soon as the far port lets go
  wire [7:0] own = req_q & ~peer_own;
  wire rd_en = !oe_n && rw_n && (ce_n ^ sem_n);
  // released bus shows a changing pattern, not the last value
  assign dq_i = rd_en ? (!ce_n ? mem[addr] : {9{~own[addr[2:0]]}}) : ~last_q;
  assign busy_n = !(stall && !ce_n);
  logic int_q = 1'b1;
  assign int_n = int_q;
  always @(posedge clk) begin
    last_q <= dq_i;
    if (!rw_n && !ce_n && sem_n && dq_oe) mem[addr] <= dq_o;
    if (!rw_n && !sem_n && ce_n) req_q[addr[2:0]] <= !dq_o[0];
    if (peer_mbox) int_q <= 1'b0;
    else if (rd_en && !ce_n && addr == 14'h3ffe) int_q <= 1'b1;
  end
endmodule
`default_nettype wire

// >>> dprh_host_bench.sv
// self-checking bench for the dual-port ram port controller
// assumes dprh_ram_model stands behind the ram pins
`default_nettype none
module dprh_host_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dprh_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, req = 1'b0, op_write = 1'b0, op_sem = 1'b0;
  logic stall = 1'b0, peer_mbox = 1'b0, ready, done, mbox_flag;
  logic ce_n, sem_n, rw_n, oe_n, dq_oe, busy_n, int_n;
  logic [7:0] peer_own = '0;
  logic [31:0] seed = 32'd94109, r;
  dprh_addr_t req_addr = '0, addr;
  dprh_data_t req_wdata = '0, rdata, dq_o, dq_i;
  dprh_addr_t wa [8];
  dprh_data_t wd [8];
  int mismatches = 0, num_checks = 0, lat;

  dprh_host dut_u (
    .clk(clk), .sys_rst(sys_rst), .req(req), .op_write(op_write), .op_sem(op_sem),
    .req_addr(req_addr), .req_wdata(req_wdata), .ready(ready), .done(done), .rdata(rdata),
    .mbox_flag(mbox_flag), .ce_n(ce_n), .sem_n(sem_n), .rw_n(rw_n), .oe_n(oe_n),
    .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .busy_n(busy_n), .int_n(int_n));
  dprh_ram_model ram_u (
    .clk(clk), .ce_n(ce_n), .sem_n(sem_n), .rw_n(rw_n), .oe_n(oe_n), .dq_oe(dq_oe),
    .addr(addr), .dq_o(dq_o), .dq_i(dq_i), .busy_n(busy_n), .int_n(int_n),
    .stall(stall), .peer_mbox(peer_mbox), .peer_own(peer_own));

  initial begin
    forever #5 clk = ~clk;
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic cmp(input dprh_data_t got, input dprh_data_t exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one request, entered at a falling edge while idle
  task automatic op(input logic w, input logic s, input dprh_addr_t a, input dprh_data_t d);
    op_write = w;
    op_sem = s;
    req_addr = a;
    req_wdata = d;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    lat = 1;
    while (done !== 1'b1 && lat < 500) begin
      @(negedge clk);
      lat++;
    end
    cmp({8'h00, done}, 9'h001);
    cmp({7'h00, ready, ce_n & sem_n}, 9'h003);
    @(negedge clk);
  endtask

  task automatic end_of_test();
    $display("mismatches %0d num_checks %0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    cmp({4'h0, ce_n, sem_n, rw_n, oe_n, dq_oe}, 9'h01e);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      wa[i] = (i == 0) ? 14'h0000 : (i == 7) ? 14'h3fff : {r[13:3], i[2:0]};
      wd[i] = r[24:16];
      op(1'b1, 1'b0, wa[i], wd[i]);
    end
    for (int i = 0; i < 8; i++) begin
      op(1'b0, 1'b0, wa[i], '0);
      cmp(rdata, wd[i]);
    end
    stall = 1'b1;
    fork
      begin
        repeat (40) @(negedge clk);
        stall = 1'b0;
      end
    join_none
    op(1'b0, 1'b0, wa[3], '0);
    cmp(rdata, wd[3]);
    cmp({8'h00, lat > 38}, 9'h001);
    stall = 1'b1;
    fork
      begin
        repeat (40) @(negedge clk);
        stall = 1'b0;
      end
    join_none
    op(1'b1, 1'b0, wa[3], ~wd[3]);
    cmp({8'h00, lat > 38}, 9'h001);
    op(1'b0, 1'b0, wa[3], '0);
    cmp(rdata, ~wd[3]);
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      peer_own = '0;
      peer_own[k] = k[0];
      op(1'b1, 1'b1, {r[13:3], k[2:0]}, {r[21:14], 1'b0});
      op(1'b0, 1'b1, 14'(k), '0);
      cmp(rdata, {9{k[0]}});
      peer_own = '0;
      op(1'b0, 1'b1, 14'(k), '0);
      cmp(rdata, 9'h000);
      op(1'b1, 1'b1, 14'(k), 9'h001);
      op(1'b0, 1'b1, 14'(k), '0);
      cmp(rdata, 9'h1ff);
    end
    op(1'b1, 1'b0, 14'h3ffe, r[8:0]);
    peer_mbox = 1'b1;
    @(negedge clk);
    peer_mbox = 1'b0;
    repeat (2) @(negedge clk);
    cmp({8'h00, mbox_flag}, 9'h001);
    op(1'b0, 1'b0, 14'h3ffe, '0);
    cmp(rdata, r[8:0]);
    repeat (2) @(negedge clk);
    cmp({8'h00, mbox_flag}, 9'h000);
    end_of_test();
  end
endmodule
`default_nettype wire
